// File: verilog/nvc_pkg.sv
// Package: constants, states and carriers for the register copy block
package nvc_pkg;
   localparam logic [3:0] NVC_ADDR_HI = 4'h9;
   localparam logic [7:0] NVC_CMD_RELOAD = 8'hB8;
   localparam logic [7:0] NVC_CMD_STORE = 8'h48;
   localparam int NVC_CLK_MHZ = 100;
   localparam int NVC_RELOAD_US = 200;
   localparam int NVC_STORE_MS = 20;
   localparam int NVC_RELOAD_CYC = NVC_RELOAD_US * NVC_CLK_MHZ;
   localparam int NVC_STORE_CYC = NVC_STORE_MS * 1000 * NVC_CLK_MHZ;
   localparam int NVC_CNT_W = 24;
   localparam logic [15:0] NVC_CFG_RST = 16'h0000;
   localparam logic [15:0] NVC_LOW_RST = 16'h4B00;
   localparam logic [15:0] NVC_HIGH_RST = 16'h5000;
   localparam int NVC_SDA_SYNC = 0;

   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] low_limit;
      logic [15:0] high_limit;
   } nvc_regs_t;

   typedef enum logic [4:0] {
      NVC_IDLE = 5'b00001,
      NVC_ADDR = 5'b00010,
      NVC_CMD = 5'b00100,
      NVC_ARMED = 5'b01000,
      NVC_SKIP = 5'b10000
   } nvc_bus_t;

   typedef enum logic [2:0] {
      NVC_OP_NONE = 3'b001,
      NVC_OP_RELOAD = 3'b010,
      NVC_OP_STORE = 3'b100
   } nvc_op_t;
endpackage

// File: verilog/nvc_edge.sv
// Start and stop detector for the two-wire bus lines
`timescale 1ns/1ps
module nvc_edge (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic start_out,
   output logic stop_out,
   output logic rise_out,
   output logic fall_out
);
   typedef struct packed {
      logic scl;
      logic sda;
   } nvc_edge_st_t;
   nvc_edge_st_t s_q, s_d;

   always_comb begin
      s_d.scl = scl_in;
      s_d.sda = sda_in;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '{scl: 1'b1, sda: 1'b1};
      end else if (en_in) begin
         s_q <= s_d;
      end
   end

   // Start and stop only while clock is high, so data edges do not alias
   assign start_out = en_in & s_q.scl & scl_in & s_q.sda & ~sda_in;
   assign stop_out = en_in & s_q.scl & scl_in & ~s_q.sda & sda_in;
   assign rise_out = en_in & ~s_q.scl & scl_in;
   assign fall_out = en_in & s_q.scl & ~scl_in;
endmodule // nvc_edge

// File: verilog/nvc_timer.sv
// Self-timed copy countdown
`timescale 1ns/1ps
module nvc_timer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic load_in,
   input wire logic [23:0] count_in,
   output logic done_out,
   output logic run_out
);
   typedef struct packed {
      logic [23:0] cnt;
      logic run;
   } nvc_tmr_st_t;
   nvc_tmr_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (load_in) begin
         s_d.cnt = count_in;
         s_d.run = 1'b1;
      end else if (s_q.run) begin
         if (s_q.cnt <= 24'h00_0001) begin
            s_d.run = 1'b0;
            s_d.cnt = '0;
         end else begin
            s_d.cnt = s_q.cnt - 24'h00_0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else if (en_in) begin
         s_q <= s_d;
      end
   end

   assign done_out = en_in & s_q.run & (s_q.cnt <= 24'h00_0001) & ~load_in;
   assign run_out = s_q.run;
endmodule // nvc_timer

// File: verilog/nvc_copy.sv
// Register copy command handler with volatile and nonvolatile sets
`timescale 1ns/1ps
// How it works
// - Reload copies nonvolatile config and limits into the live registers.
// - Reset itself starts a reload with no command needed.
// - A write address 1001 plus the strapped pins is acknowledged.
// - Command byte B8h selects reload and is acknowledged.
// - Reload starts only on Stop; a repeated Start drops it untouched.
// - Busy flag stays 1 for the whole reload, which ends in its time.
// - Reload is dropped when busy, lock or lockdown is set.
// - A dropped reload still acknowledges the command byte.
// - Store copies live config and limits into nonvolatile defaults.
// - Command byte 48h selects store and is acknowledged.
// - Busy flag stays 1 for the whole store, which ends in its time.
// - Store starts only on Stop; a repeated Start drops it untouched.
// - Store is dropped when busy, lock or lockdown is set.
// - A dropped store still acknowledges the command byte.
// - A copy opcode leaves the pointer register as it was.
module nvc_copy #(
   parameter int RELOAD_CYC = nvc_pkg::NVC_RELOAD_CYC,
   parameter int STORE_CYC = nvc_pkg::NVC_STORE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [2:0] addr_pins_in,
   input wire logic vol_we_in,
   input wire nvc_pkg::nvc_regs_t vol_wdata_in,
   input wire logic [7:0] ptr_in,
   input wire logic ptr_we_in,
   input wire logic lock_bit_in,
   input wire logic lockdown_bit_in,
   output nvc_pkg::nvc_regs_t vol_out,
   output nvc_pkg::nvc_regs_t nv_out,
   output logic [7:0] ptr_out,
   output logic nv_busy_flag_out,
   output logic reg_lock_bit_out,
   output logic reg_lockdown_bit_out
);
   import nvc_pkg::*;

   // ********************************
   // State
   // ********************************
   typedef struct packed {
      nvc_bus_t bus;
      nvc_op_t pend;
      nvc_op_t run;
      logic [3:0] bits;
      logic [7:0] shreg;
      logic ack;
      logic boot;
      nvc_regs_t vol;
      nvc_regs_t nv;
      logic [7:0] ptr;
      logic lock;
      logic lockdown;
   } nvc_st_t;
   // Power-up image: nonvolatile set and locks keep it across resets
   nvc_st_t s_q = '{bus: NVC_IDLE, pend: NVC_OP_NONE, run: NVC_OP_NONE,
      bits: 4'h0, shreg: 8'h00, ack: 1'b0, boot: 1'b1,
      vol: '{NVC_CFG_RST, NVC_LOW_RST, NVC_HIGH_RST},
      nv: '{NVC_CFG_RST, NVC_LOW_RST, NVC_HIGH_RST},
      ptr: 8'h00, lock: 1'b0, lockdown: 1'b0};
   nvc_st_t s_d;

   logic start_w, stop_w, rise_w, fall_w;
   logic tmr_load, tmr_done, tmr_run;
   logic [23:0] tmr_count;
   logic blocked;

   nvc_edge u_edge (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .en_in(en_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .start_out(start_w),
      .stop_out(stop_w),
      .rise_out(rise_w),
      .fall_out(fall_w)
   );

   nvc_timer u_timer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .en_in(en_in),
      .load_in(tmr_load),
      .count_in(tmr_count),
      .done_out(tmr_done),
      .run_out(tmr_run)
   );

   // ********************************
   // Next state
   // ********************************
   // Lock and lockdown gate every commanded copy, not the reset reload; busy covers a copy in flight
   assign blocked = (s_q.run != NVC_OP_NONE) | s_q.lock | s_q.lockdown;

   always_comb begin
      s_d = s_q;
      tmr_load = 1'b0;
      tmr_count = '0;
      s_d.boot = 1'b0;
      if (s_q.boot) begin
         s_d.run = NVC_OP_RELOAD;
         tmr_load = 1'b1;
         tmr_count = RELOAD_CYC[23:0];
      end
      if (vol_we_in && !blocked) begin
         s_d.vol = vol_wdata_in;
      end
      if (ptr_we_in) begin
         s_d.ptr = ptr_in;
      end
      // Lockdown is one-time: it can be set but never cleared
      if (lockdown_bit_in) begin
         s_d.lockdown = 1'b1;
      end
      if (!s_q.lockdown) begin
         s_d.lock = lock_bit_in;
      end
      // Byte receiver: shift on rising clock, ack slot on ninth bit
      if (rise_w && s_q.bits < 4'd8) begin
         s_d.shreg = {s_q.shreg[6:0], sda_in};
         s_d.bits = s_q.bits + 4'd1;
      end
      if (fall_w) begin
         if (s_q.ack) begin
            s_d.ack = 1'b0;
            s_d.bits = 4'd0;
         end else if (s_q.bits == 4'd8) begin
            s_d.bits = 4'd0;
            case (s_q.bus)
               NVC_ADDR: begin
                  if (s_q.shreg == {NVC_ADDR_HI, addr_pins_in, 1'b0}) begin
                     s_d.ack = 1'b1;
                     s_d.bus = NVC_CMD;
                  end else begin
                     s_d.bus = NVC_SKIP;
                  end
               end
               NVC_CMD: begin
                  // Opcode is acked even when it will be dropped
                  s_d.ack = 1'b1;
                  s_d.bus = NVC_ARMED;
                  if (s_q.shreg == NVC_CMD_RELOAD) begin
                     s_d.pend = blocked ? NVC_OP_NONE
                                        : NVC_OP_RELOAD;
                  end else if (s_q.shreg == NVC_CMD_STORE) begin
                     s_d.pend = blocked ? NVC_OP_NONE
                                        : NVC_OP_STORE;
                  end else begin
                     s_d.pend = NVC_OP_NONE;
                     s_d.ack = 1'b0;
                     s_d.bus = NVC_SKIP;
                  end
                  // Opcodes never touch the pointer
               end
               default: begin
                  s_d.bus = NVC_SKIP;
               end
            endcase
         end
      end
      // Repeated Start drops any pending copy
      if (start_w) begin
         s_d.bus = NVC_ADDR;
         s_d.bits = 4'd0;
         s_d.ack = 1'b0;
         s_d.pend = NVC_OP_NONE;
      end
      if (stop_w) begin
         s_d.bus = NVC_IDLE;
         s_d.bits = 4'd0;
         s_d.ack = 1'b0;
         s_d.pend = NVC_OP_NONE;
         case (s_q.pend)
            NVC_OP_RELOAD: begin
               s_d.run = NVC_OP_RELOAD;
               tmr_load = 1'b1;
               tmr_count = RELOAD_CYC[23:0];
            end
            NVC_OP_STORE: begin
               s_d.run = NVC_OP_STORE;
               tmr_load = 1'b1;
               tmr_count = STORE_CYC[23:0];
            end
            default: begin
               s_d.pend = NVC_OP_NONE;
            end
         endcase
      end
      // Data moves at the end of the timed copy, on the same edge that busy drops
      if (tmr_done) begin
         case (s_q.run)
            NVC_OP_RELOAD: s_d.vol = s_q.nv;
            NVC_OP_STORE: s_d.nv = s_q.vol;
            default: s_d.vol = s_q.vol;
         endcase
         s_d.run = NVC_OP_NONE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q.bus <= NVC_IDLE;
         s_q.pend <= NVC_OP_NONE;
         s_q.run <= NVC_OP_NONE;
         s_q.bits <= 4'h0;
         s_q.shreg <= 8'h00;
         s_q.ack <= 1'b0;
         s_q.boot <= 1'b1;
         s_q.vol <= '{NVC_CFG_RST, NVC_LOW_RST, NVC_HIGH_RST};
         // Nonvolatile copy and locks survive reset
         s_q.ptr <= 8'h00;
      end else if (en_in) begin
         s_q <= s_d;
      end
   end

   // ********************************
   // Outputs
   // ********************************
   assign sda_out = 1'b0;
   assign sda_oe_out = s_q.ack;
   assign vol_out = s_q.vol;
   assign nv_out = s_q.nv;
   assign ptr_out = s_q.ptr;
   assign nv_busy_flag_out = (s_q.run != NVC_OP_NONE);
   assign reg_lock_bit_out = s_q.lock;
   assign reg_lockdown_bit_out = s_q.lockdown;

   // ********************************
   // Checks
   // ********************************
   property p_busy_timer;
      @(posedge clk_in) disable iff (rst_in)
      tmr_run |-> nv_busy_flag_out;
   endproperty
   a_busy_timer: assert property (p_busy_timer) else $error("busy low");

   property p_store_busy;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && stop_w && s_q.pend == NVC_OP_STORE) |=> nv_busy_flag_out;
   endproperty
   a_store_busy: assert property (p_store_busy) else $error("no store");

   property p_rs_abort;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && start_w) |=> s_q.pend == NVC_OP_NONE;
   endproperty
   a_rs_abort: assert property (p_rs_abort) else $error("rs kept");

   property p_rs_store;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && start_w && !nv_busy_flag_out) |=> !nv_busy_flag_out;
   endproperty
   a_rs_store: assert property (p_rs_store) else $error("rs ran");

   property p_lock_reload;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && fall_w && !s_q.ack && s_q.bus == NVC_CMD
       && s_q.bits == 4'd8 && (nv_busy_flag_out || reg_lock_bit_out
       || reg_lockdown_bit_out)) |=> s_q.pend == NVC_OP_NONE;
   endproperty
   a_lock_reload: assert property (p_lock_reload) else $error("lock");

   property p_lock_store;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && fall_w && !s_q.ack && s_q.bus == NVC_CMD
       && s_q.bits == 4'd8 && s_q.shreg == NVC_CMD_STORE
       && (reg_lock_bit_out || reg_lockdown_bit_out))
      |=> s_q.pend == NVC_OP_NONE;
   endproperty
   a_lock_store: assert property (p_lock_store) else $error("nv chg");

   property p_ack_cmd;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && fall_w && !s_q.ack && s_q.bus == NVC_CMD
       && s_q.bits == 4'd8 && (s_q.shreg == NVC_CMD_RELOAD
       || s_q.shreg == NVC_CMD_STORE)) |=> sda_oe_out;
   endproperty
   a_ack_cmd: assert property (p_ack_cmd) else $error("no ack");

   property p_ptr;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && !ptr_we_in) |=> $stable(ptr_out);
   endproperty
   a_ptr: assert property (p_ptr) else $error("ptr chg");

   property p_done;
      @(posedge clk_in) disable iff (rst_in)
      (en_in && tmr_done) |=> !nv_busy_flag_out;
   endproperty
   a_done: assert property (p_done) else $error("busy stuck");

   c_store: cover property (@(posedge clk_in) disable iff (rst_in)
      en_in && stop_w && s_q.pend == NVC_OP_STORE);
   c_reload: cover property (@(posedge clk_in) disable iff (rst_in)
      en_in && stop_w && s_q.pend == NVC_OP_RELOAD);
   c_abort: cover property (@(posedge clk_in) disable iff (rst_in)
      en_in && start_w && s_q.pend != NVC_OP_NONE);
endmodule // nvc_copy

// File: verif/nvc_master.sv
// Two-wire bus master model for the copy command frames
`timescale 1ns/1ps
module nvc_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   // ********
   // Bus idle
   // ********
   // SCL stands high outside frames; SDA is released to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Start or repeated start: SDA falls while SCL is high
   task automatic start();
      scl_out <= 1'b0;
      tick(2);
      sda_out <= 1'b1;
      tick(2);
      scl_out <= 1'b1;
      tick(4);
      sda_out <= 1'b0;
      tick(4);
      scl_out <= 1'b0;
      tick(2);
   endtask
   // Byte out MSB first, then release SDA for the ninth clock
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_out <= b[i];
         tick(2);
         scl_out <= 1'b1;
         tick(4);
         scl_out <= 1'b0;
         tick(2);
      end
      sda_out <= 1'b1;
      tick(2);
      scl_out <= 1'b1;
      tick(2);
      ack = ~sda_in;
      tick(2);
      scl_out <= 1'b0;
      tick(2);
   endtask
   // Stop: SDA rises while SCL is high
   task automatic stop();
      sda_out <= 1'b0;
      tick(2);
      scl_out <= 1'b1;
      tick(4);
      sda_out <= 1'b1;
      tick(4);
   endtask
endmodule // nvc_master

// File: verif/nv_register_copy_commands_tb_top.sv
// Self-checking bench for the register copy block
`timescale 1ns/1ps
module nv_register_copy_commands_tb_top;
   import nvc_pkg::*;
   localparam int RCYC = 200;
   localparam int SCYC = 400;
   typedef struct {nvc_regs_t vol; nvc_regs_t nv; int len;} nvc_note_t;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic scl;
   logic sda_m;
   logic sda_o;
   logic sda_oe;
   logic [2:0] pins = 3'h5;
   logic vol_we = 1'b0;
   nvc_regs_t vol_wd = '0;
   logic [7:0] ptr = 8'h00;
   logic ptr_we = 1'b0;
   logic lock = 1'b0;
   logic lockdn = 1'b0;
   nvc_regs_t vol_o;
   nvc_regs_t nv_o;
   logic [7:0] ptr_o;
   logic busy;
   logic lk_o;
   logic ld_o;
   nvc_regs_t vol_e;
   nvc_regs_t nv_e;
   logic [7:0] ptr_e;
   nvc_note_t q[$];
   nvc_note_t n;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 65364;
   int cnt = 0;
   logic a;
   // Open-drain SDA with pull-up: low if either side pulls
   wire sda = sda_m & ~sda_oe;
   always #5 clk_in = ~clk_in;
   nvc_copy #(.RELOAD_CYC(RCYC), .STORE_CYC(SCYC)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .en_in(1'b1), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .addr_pins_in(pins), .vol_we_in(vol_we), .vol_wdata_in(vol_wd),
      .ptr_in(ptr), .ptr_we_in(ptr_we), .lock_bit_in(lock),
      .lockdown_bit_in(lockdn), .vol_out(vol_o), .nv_out(nv_o),
      .ptr_out(ptr_o), .nv_busy_flag_out(busy), .reg_lock_bit_out(lk_o),
      .reg_lockdown_bit_out(ld_o));
   nvc_master u_mst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
      .sda_out(sda_m));
   // ****************
   // Checking helpers
   // ****************
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Each busy period ends with one copy that must match the oldest note
   always @(posedge clk_in) begin
      if (busy === 1'b1) cnt++;
      else if (cnt != 0) begin
         if (q.size() == 0) check(48'h1, 48'h0);
         else begin
            n = q.pop_front();
            check(vol_o, n.vol);
            check(nv_o, n.nv);
            check({47'h0, (cnt <= n.len)}, 48'h1);
         end
         cnt = 0;
      end
   end
   task automatic wr_vol();
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      vol_wd <= r[47:0];
      vol_we <= 1'b1;
      @(posedge clk_in);
      vol_we <= 1'b0;
      vol_e = r[47:0];
      repeat (2) @(posedge clk_in);
      check(vol_o, vol_e);
   endtask
   // Note is taken before Stop since busy rises just after it
   task automatic cmd(input logic [7:0] op, input logic abort, take);
      u_mst.start();
      u_mst.send({NVC_ADDR_HI, pins, 1'b0}, a);
      check({47'h0, a}, 48'h1);
      check({47'h0, sda_o}, 48'h0);
      u_mst.send(op, a);
      check({47'h0, a}, 48'h1);
      if (take && op == NVC_CMD_RELOAD) vol_e = nv_e;
      if (take && op == NVC_CMD_STORE) nv_e = vol_e;
      if (take) q.push_back('{vol_e, nv_e, (op == NVC_CMD_STORE) ? SCYC : RCYC});
      if (abort) u_mst.start();
      u_mst.stop();
      repeat (3) @(posedge clk_in);
   endtask
   task automatic settle();
      int k;
      k = 0;
      // Busy rises one edge after reset release or Stop; let it show first
      repeat (2) @(posedge clk_in);
      while (busy !== 1'b0 && k < SCYC + 50) begin
         @(posedge clk_in);
         k++;
      end
      repeat (3) @(posedge clk_in);
      check({47'h0, busy}, 48'h0);
      check(vol_o, vol_e);
      check(nv_o, nv_e);
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      logic [63:0] r;
      vol_e = {NVC_CFG_RST, NVC_LOW_RST, NVC_HIGH_RST};
      nv_e = vol_e;
      q.push_back('{vol_e, nv_e, RCYC});
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      settle();
      r = {$random(seed), $random(seed)};
      ptr <= r[7:0];
      ptr_we <= 1'b1;
      @(posedge clk_in);
      ptr_we <= 1'b0;
      ptr_e = r[7:0];
      // Few stores only, well inside endurance
      wr_vol();
      cmd(NVC_CMD_STORE, 1'b0, 1'b1);
      settle();
      wr_vol();
      cmd(NVC_CMD_RELOAD, 1'b0, 1'b1);
      settle();
      wr_vol();
      cmd(NVC_CMD_RELOAD, 1'b1, 1'b0);
      settle();
      cmd(NVC_CMD_STORE, 1'b1, 1'b0);
      settle();
      u_mst.start();
      u_mst.send({NVC_ADDR_HI, ~pins, 1'b0}, a);
      check({47'h0, a}, 48'h0);
      u_mst.stop();
      cmd(NVC_CMD_STORE, 1'b0, 1'b1);
      cmd(NVC_CMD_RELOAD, 1'b0, 1'b0);
      settle();
      wr_vol();
      cmd(NVC_CMD_STORE, 1'b0, 1'b1);
      cmd(NVC_CMD_STORE, 1'b0, 1'b0);
      settle();
      lock <= 1'b1;
      repeat (3) @(posedge clk_in);
      check({47'h0, lk_o}, 48'h1);
      cmd(NVC_CMD_RELOAD, 1'b0, 1'b0);
      settle();
      cmd(NVC_CMD_STORE, 1'b0, 1'b0);
      settle();
      lock <= 1'b0;
      repeat (3) @(posedge clk_in);
      check({40'h0, ptr_o}, {40'h0, ptr_e});
      lockdn <= 1'b1;
      @(posedge clk_in);
      lockdn <= 1'b0;
      repeat (3) @(posedge clk_in);
      check({47'h0, ld_o}, 48'h1);
      cmd(NVC_CMD_RELOAD, 1'b0, 1'b0);
      settle();
      cmd(NVC_CMD_STORE, 1'b0, 1'b0);
      settle();
      check({47'h0, (q.size() == 0)}, 48'h1);
      close_out();
   end
   // Whole run is near 3.5k cycles; this cuts a hang at 50k cycles
   initial begin
      #500_000;
      num_errors++;
      close_out();
   end
endmodule // nv_register_copy_commands_tb_top
